// *** hw/analog_hold_formatter.sv ***
// Top of the analog input hold formatter: AXI4-Lite register slave,
// per-channel resolution scaling and per-channel track-and-hold.
// Assumes conversions arrive synchronous to aclk as a 16-bit code that
// spans the selected voltage range, tagged with their channel number.
`timescale 1ns/1ps

// Operation
// - 12-bit channels report 0 at zero volts up to 4095 at full scale.
// - 14-bit channels report 0 at zero volts up to 16383 at full scale.
// - 16-bit channels report 0 at zero volts up to 65535 at full scale.
// - Count is proportional to voltage over the selected range.
// - Each channel result fits one 16-bit data word.
// - Hold behaviour is chosen separately for each channel.
// - With no hold, each update places the live result.
// - Minimum hold captures first sample, then keeps only strictly lower ones.
// - Maximum hold captures first sample, then keeps only strictly higher ones.
// - In the reset setting the live result is reported.
// - Leaving reset for min or max restarts capture afresh.
// - Two bits per channel select 12, 14, 16 bit or disabled.
// - Hold codes: 00 live, 01 min, 10 max, 11 reset; changeable anytime.
module analog_hold_formatter #(
  parameter int NUM_CH = analog_hold_pkg::NUM_CH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sample_valid,
  input  wire logic [2:0]  sample_channel,
  input  wire logic [15:0] sample_raw,
  output logic             input_range_10v,
  output logic             output_range_10v
);

  // Configuration registers.
  logic [15:0] resolution_sel;
  logic [15:0] range_sel;
  logic [15:0] hold_sel;
  logic [15:0] next_resolution_sel;
  logic [15:0] next_range_sel;
  logic [15:0] next_hold_sel;

  // Write channel state.
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        next_aw_held;
  logic [7:0]  next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;

  // Read channel state.
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Per-channel data and flags.
  logic [15:0]       data_word [NUM_CH];
  logic [NUM_CH-1:0] captured;
  logic [NUM_CH-1:0] fresh;
  logic [NUM_CH-1:0] next_fresh;
  logic [NUM_CH-1:0] ch_hit;
  logic [15:0]       sample_count;
  logic [1:0]        sample_res;

  logic        do_write;
  logic        ar_take;
  logic        data_read;
  logic [2:0]  read_index;

  function automatic logic [15:0] merge16(logic [15:0] old_value,
                                          logic [31:0] wdata,
                                          logic [3:0]  wstrb);
    logic [15:0] v;
    v = old_value;
    if (wstrb[0]) begin
      v[7:0] = wdata[7:0];
    end
    if (wstrb[1]) begin
      v[15:8] = wdata[15:8];
    end
    return v;
  endfunction

  function automatic logic is_data_addr(logic [7:0] addr);
    return addr >= analog_hold_pkg::ADDR_DATA_FIRST &&
           addr <= analog_hold_pkg::ADDR_DATA_LAST;
  endfunction

  function automatic logic [2:0] data_index(logic [7:0] addr);
    logic [7:0] off;
    off = (addr - analog_hold_pkg::ADDR_DATA_FIRST) >>
          analog_hold_pkg::WORD_SHIFT;
    return off[2:0];
  endfunction

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  assign input_range_10v  = range_sel[analog_hold_pkg::RANGE_IN_BIT];
  assign output_range_10v = range_sel[analog_hold_pkg::RANGE_OUT_BIT];

  // Write path: address and data may arrive in either order.
  always_comb begin
    next_aw_held        = aw_held;
    next_aw_addr        = aw_addr;
    next_w_held         = w_held;
    next_w_data         = w_data;
    next_w_strb         = w_strb;
    next_bvalid         = bvalid;
    next_bresp          = bresp;
    next_resolution_sel = resolution_sel;
    next_range_sel      = range_sel;
    next_hold_sel       = hold_sel;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = analog_hold_pkg::RESP_OKAY;
      case (aw_addr)
        analog_hold_pkg::ADDR_RESOLUTION:
          next_resolution_sel = merge16(resolution_sel, w_data,
                                        w_strb);
        analog_hold_pkg::ADDR_RANGE:
          next_range_sel = merge16(range_sel, w_data, w_strb);
        analog_hold_pkg::ADDR_HOLD:
          next_hold_sel = merge16(hold_sel, w_data, w_strb);
        default:
          next_bresp = analog_hold_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      aw_addr        <= 8'h00;
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      bvalid         <= 1'b0;
      bresp          <= analog_hold_pkg::RESP_OKAY;
      resolution_sel <= analog_hold_pkg::RESOLUTION_RESET;
      range_sel      <= analog_hold_pkg::RANGE_RESET;
      hold_sel       <= analog_hold_pkg::HOLD_RESET;
    end else begin
      aw_held        <= next_aw_held;
      aw_addr        <= next_aw_addr;
      w_held         <= next_w_held;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      bvalid         <= next_bvalid;
      bresp          <= next_bresp;
      resolution_sel <= next_resolution_sel;
      range_sel      <= next_range_sel;
      hold_sel       <= next_hold_sel;
    end
  end

  // Read path: one cycle from the address handshake to rvalid.
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    ar_take     = s_axi_arvalid && s_axi_arready;
    data_read   = ar_take && is_data_addr(s_axi_araddr);
    read_index  = data_index(s_axi_araddr);
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp  = analog_hold_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (data_read) begin
        next_rdata[15:0] = data_word[read_index];
      end else begin
        case (s_axi_araddr)
          analog_hold_pkg::ADDR_RESOLUTION:
            next_rdata[15:0] = resolution_sel;
          analog_hold_pkg::ADDR_RANGE:
            next_rdata[15:0] = range_sel;
          analog_hold_pkg::ADDR_HOLD:
            next_rdata[15:0] = hold_sel;
          analog_hold_pkg::ADDR_STATUS: begin
            next_rdata[analog_hold_pkg::STATUS_CAPTURED_LSB +: 8] = captured;
            next_rdata[analog_hold_pkg::STATUS_FRESH_LSB +: 8]    = fresh;
          end
          default:
            next_rresp = analog_hold_pkg::RESP_SLVERR;
        endcase
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= analog_hold_pkg::RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

  // The incoming sample is scaled once, at its own channel's resolution.
  assign sample_res = resolution_sel[sample_channel * 2 +: 2];

  resolution_scaler u_scaler (
    .raw   (sample_raw),
    .res   (sample_res),
    .count (sample_count)
  );

  // Fresh flags: set by an update, cleared by reading that data word.
  // A set in the same cycle as the clearing read wins, so no update is missed.
  always_comb begin
    next_fresh = fresh;
    for (int i = 0; i < NUM_CH; i++) begin
      if (data_read && read_index == i[2:0]) begin
        next_fresh[i] = 1'b0;
      end
      if (ch_hit[i]) begin
        next_fresh[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fresh <= '0;
    end else begin
      fresh <= next_fresh;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign ch_hit[c] = sample_valid && sample_channel == 3'(c) &&
                       resolution_sel[c*2 +: 2] != analog_hold_pkg::RES_OFF;

    hold_channel u_hold (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .sample_valid (ch_hit[c]),
      .count        (sample_count),
      .res          (resolution_sel[c*2 +: 2]),
      .mode         (hold_sel[c*2 +: 2]),
      .data_word    (data_word[c]),
      .captured     (captured[c])
    );
  end

endmodule // analog_hold_formatter

// *** hw/analog_hold_pkg.sv ***
// Shared constants for the analog input hold formatter: register map,
// field codes, resolution limits and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus and eight input channels.
package analog_hold_pkg;

  localparam int NUM_CH  = 8;
  localparam int COUNT_W = 16;
  localparam int SEL_W   = 2;
  localparam int CH_W    = 3;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_RESOLUTION = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RANGE      = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_HOLD       = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_DATA_FIRST = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_DATA_LAST  = 8'h2c;
  localparam int                WORD_SHIFT      = 2;

  // Reset values.
  localparam logic [15:0] RESOLUTION_RESET = 16'h0000;
  localparam logic [15:0] RANGE_RESET      = 16'h0000;
  localparam logic [15:0] HOLD_RESET       = 16'h0000;

  // Range register fields.
  localparam int RANGE_IN_BIT  = 0;
  localparam int RANGE_OUT_BIT = 8;

  // Status register fields.
  localparam int STATUS_CAPTURED_LSB = 0;
  localparam int STATUS_FRESH_LSB    = 8;

  // Per-channel resolution codes.
  localparam logic [SEL_W-1:0] RES_12  = 2'h0;
  localparam logic [SEL_W-1:0] RES_14  = 2'h1;
  localparam logic [SEL_W-1:0] RES_16  = 2'h2;
  localparam logic [SEL_W-1:0] RES_OFF = 2'h3;

  // Per-channel track-and-hold codes.
  localparam logic [SEL_W-1:0] HOLD_LIVE  = 2'h0;
  localparam logic [SEL_W-1:0] HOLD_MIN   = 2'h1;
  localparam logic [SEL_W-1:0] HOLD_MAX   = 2'h2;
  localparam logic [SEL_W-1:0] HOLD_RESET_SEL = 2'h3;

  // Full-scale counts per resolution.
  localparam logic [COUNT_W-1:0] MAX_12 = 16'h0fff;
  localparam logic [COUNT_W-1:0] MAX_14 = 16'h3fff;
  localparam logic [COUNT_W-1:0] MAX_16 = 16'hffff;

  // Right shift of the 16-bit full-range conversion per resolution.
  localparam int SHIFT_12 = 4;
  localparam int SHIFT_14 = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [COUNT_W-1:0] max_count(logic [SEL_W-1:0] res);
    logic [COUNT_W-1:0] m;
    m = 16'h0000;
    case (res)
      RES_12:  m = MAX_12;
      RES_14:  m = MAX_14;
      RES_16:  m = MAX_16;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

endpackage

// *** hw/hold_channel.sv ***
// One channel's track-and-hold stage and its 16-bit data word.
// Assumes count is already at the channel's resolution and is valid with
// sample_valid for one cycle per conversion of this channel.
`timescale 1ns/1ps
module hold_channel (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sample_valid,
  input  wire logic [15:0] count,
  input  wire logic [1:0]  res,
  input  wire logic [1:0]  mode,
  output logic      [15:0] data_word,
  output logic             captured
);

  logic [15:0] held;
  logic [3:0]  last_cfg;
  logic [15:0] next_data_word;
  logic [15:0] next_held;
  logic        next_captured;
  logic [3:0]  next_last_cfg;
  logic        cfg_changed;
  logic        have;

  always_comb begin
    cfg_changed    = {res, mode} != last_cfg;
    // Any change of mode or resolution drops history, so a stale value
    // from another scale never wins a comparison.
    have           = captured && !cfg_changed;
    next_data_word = data_word;
    next_held      = held;
    next_captured  = have;
    next_last_cfg  = {res, mode};
    if (res == analog_hold_pkg::RES_OFF) begin
      next_data_word = 16'h0000;
      next_captured  = 1'b0;
    end else if (mode == analog_hold_pkg::HOLD_RESET_SEL) begin
      next_captured = 1'b0;
      if (sample_valid) begin
        next_data_word = count;
      end
    end else if (sample_valid) begin
      unique case (mode)
        analog_hold_pkg::HOLD_MIN: begin
          if (!have && count <= analog_hold_pkg::max_count(res)) begin
            next_held     = count;
            next_captured = 1'b1;
          end else if (have && count < held) begin
            next_held = count;
          end
          next_data_word = next_held;
        end
        analog_hold_pkg::HOLD_MAX: begin
          if (!have) begin
            next_held     = count;
            next_captured = 1'b1;
          end else if (count > held) begin
            next_held = count;
          end
          next_data_word = next_held;
        end
        default: begin
          next_data_word = count;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_word <= 16'h0000;
      held      <= 16'h0000;
      captured  <= 1'b0;
      last_cfg  <= 4'h0;
    end else begin
      data_word <= next_data_word;
      held      <= next_held;
      captured  <= next_captured;
      last_cfg  <= next_last_cfg;
    end
  end

endmodule // hold_channel

// *** hw/resolution_scaler.sv ***
// Maps a 16-bit full-range conversion onto the selected channel resolution.
// Assumes the raw code already spans the selected voltage range end to end.
`timescale 1ns/1ps
module resolution_scaler (
  input  wire logic [15:0] raw,
  input  wire logic [1:0]  res,
  output logic      [15:0] count
);

  // A shift keeps zero at zero and full scale at the resolution maximum
  // while staying proportional, at the cost of a divider-free floor.
  always_comb begin
    count = 16'h0000;
    case (res)
      analog_hold_pkg::RES_12: count = raw >> analog_hold_pkg::SHIFT_12;
      analog_hold_pkg::RES_14: count = raw >> analog_hold_pkg::SHIFT_14;
      analog_hold_pkg::RES_16: count = raw;
      default:                 count = 16'h0000;
    endcase
  end

endmodule // resolution_scaler

// *** sim/hold_sva.sv ***
// Concurrent checks on the formatter's register bus and range pins.
// Assumes it is bound to analog_hold_formatter and sees only its ports.
`timescale 1ns/1ps
module hold_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        input_range_10v,
  input wire logic        output_range_10v
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_wr_answer;
    s_wr_both |-> ##2 s_axi_bvalid;
  endproperty
  property p_unmapped;
    s_ar_take and s_axi_araddr > 8'h2c |=>
      s_axi_rresp == analog_hold_pkg::RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  property p_word16;
    s_ar_take and s_axi_araddr inside {[8'h10:8'h2c]} |=>
      s_axi_rdata[31:16] == 16'h0000;
  endproperty
  property p_range_cause;
    $changed({input_range_10v, output_range_10v}) |-> $rose(s_axi_bvalid);
  endproperty
  property p_rst_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready;
  endproperty
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped early");
  a_r_stands: assert property (p_r_stands)
    else $error("read data dropped early");
  a_ar_answer: assert property (p_ar_answer)
    else $error("read answer late");
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read taken while busy");
  a_w_refuse: assert property (p_w_refuse)
    else $error("write taken while busy");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_word16: assert property (p_word16)
    else $error("data word wider than 16 bits");
  a_range_cause: assert property (p_range_cause)
    else $error("range pin moved without a write");
  a_rst_idle: assert property (p_rst_idle)
    else $error("bus not idle after reset");
endmodule // hold_sva

bind analog_hold_formatter hold_sva u_sva (.*);

// *** sim/host_master.sv ***
// Register bus master standing in for the host controller CPU.
// Assumes its tasks are called just after a rising edge of aclk.
`timescale 1ns/1ps
module host_master (
  input  wire logic        aclk,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Released lines are inverted so stale values are never mistaken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input int st);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (st) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input int st);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (st) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule // host_master

// *** sim/testbench.sv ***
// Self-checking bench for the analog input hold formatter.
// Assumes host_master drives the register bus and hold_sva is bound.
`timescale 1ns/1ps
module testbench;
  localparam logic [1:0] OK = analog_hold_pkg::RESP_OKAY;
  localparam logic [1:0] ER = analog_hold_pkg::RESP_SLVERR;
  logic        aclk, aresetn, sample_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot, sample_channel;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        input_range_10v, output_range_10v;
  logic [15:0] sample_raw, mn, mx, v;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          err_total, n_checks;

  analog_hold_formatter dut (.*);
  host_master hm (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] scale(input int r, input logic [15:0] x);
    case (r)
      0: return x >> 4;
      1: return x >> 2;
      2: return x;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_pin(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      cmp_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      cmp_pin(bq.pop_front(), s_axi_bresp);
  end

  task automatic rd(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] r, input int st);
    rq.push_back({r, 16'h0000, d});
    hm.rd(a, st);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    hm.wr(a, d, int'(d[0]) + 1);
  endtask
  task automatic smp(input logic [2:0] c, input logic [15:0] x);
    sample_valid <= 1'b1;
    sample_channel <= c;
    sample_raw <= x;
    @(posedge aclk);
    sample_valid <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    close_out();
  end

  initial begin
    aresetn = 1'b0;
    sample_valid = 1'b0;
    sample_channel = 3'h0;
    sample_raw = 16'h0000;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    err_total = 0;
    n_checks = 0;
    seed = 32'h5bd2d24e;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 16'h0000, OK, 0);
    rd(8'h08, 16'h0000, OK, 2);
    rd(8'h30, 16'h0000, ER, 0);
    wr(8'h0c, 32'h0000ffff, ER);
    wr(8'h04, 32'h00000101, OK);
    cmp_pin(2'b11, {input_range_10v, output_range_10v});
    rd(8'h04, 16'h0101, OK, 1);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      wr(8'h00, 32'(r), OK);
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        v = (k == 0) ? 16'h0000 : (k == 1) ? 16'hffff : seed[15:0];
        smp(3'h0, v);
        rd(8'h10, scale(r, v), OK, k);
      end
    end
    $display("test scaling done");
    wr(8'h00, 32'h00000028, OK);
    wr(8'h08, 32'h00000024, OK);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      v = seed[15:0];
      mn = (k == 0 || v < mn) ? v : mn;
      mx = (k == 0 || v > mx) ? v : mx;
      smp(3'h1, v);
      smp(3'h2, v);
      rd(8'h14, mn, OK, 0);
      rd(8'h18, mx, OK, 1);
    end
    rd(8'h0c, 16'h0006, OK, 0);
    $display("test hold done");
    wr(8'h08, 32'h0000002c, OK);
    smp(3'h1, 16'hffff);
    smp(3'h2, 16'h0000);
    rd(8'h0c, 16'h0604, OK, 0);
    rd(8'h14, 16'hffff, OK, 0);
    rd(8'h18, mx, OK, 0);
    wr(8'h08, 32'h00000024, OK);
    smp(3'h1, 16'hfffe);
    rd(8'h14, 16'hfffe, OK, 0);
    smp(3'h1, 16'hffff);
    rd(8'h14, 16'hfffe, OK, 0);
    $display("test hold reset done");
    @(posedge aclk);
    close_out();
  end
endmodule // testbench
